// file: inc/lrm_params.svh
`ifndef LRM_PARAMS_SVH
`define LRM_PARAMS_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define LRM_AW              7
`define LRM_DW              8
`define LRM_FIFO_DEPTH      256

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define LRM_ADDR_FIFO       7'h00
`define LRM_ADDR_OPMODE     7'h01
`define LRM_ADDR_RSVD_LO    7'h02
`define LRM_ADDR_RSVD_HI    7'h05
`define LRM_ADDR_FRF_MSB    7'h06
`define LRM_ADDR_SHARED_LO  7'h0d
`define LRM_ADDR_SHARED_HI  7'h3f

// ----------------------------------------------------------------------
// operating-mode field positions
// ----------------------------------------------------------------------
`define LRM_MODEM_BIT       7
`define LRM_SHARED_BIT      6
`define LRM_RSVD_MSB        5
`define LRM_RSVD_LSB        4
`define LRM_BAND_BIT        3
`define LRM_MODE_MSB        2
`define LRM_MODE_LSB        0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LRM_MODEM_RST       1'b0
`define LRM_SHARED_RST      1'b0
`define LRM_BAND_RST        1'b1
`define LRM_FRF_MSB_RST     8'h6c
`define LRM_RDATA_IDLE      8'h00
`define LRM_RSVD_VALUE      2'h0

`endif

// file: inc/lrm_pkg.sv
`default_nettype none

`include "lrm_params.svh"

package lrm_pkg;

    // device modes
    typedef enum logic [2:0] {
        lrm_sleep               = 3'b000,
        standby_state           = 3'b001,
        tx_synth_state          = 3'b010,
        lrm_transmit            = 3'b011,
        rx_synth_state          = 3'b100,
        rx_continuous_state     = 3'b101,
        rx_one_shot_state       = 3'b110,
        channel_activity_detect = 3'b111
    } lrm_mode_t;

    // address regions seen by the register port
    typedef enum logic [2:0] {
        lrm_rg_fifo   = 3'b000,
        lrm_rg_opmode = 3'b001,
        lrm_rg_rsvd   = 3'b010,
        lrm_rg_frf    = 3'b011,
        lrm_rg_shared = 3'b100,
        lrm_rg_other  = 3'b101
    } lrm_region_t;

    // register block state
    typedef struct packed {
        logic                modem_select;
        logic                shared_page_access;
        logic                band_bank_select;
        lrm_mode_t           mode;
        logic [`LRM_DW-1:0]  carrier_freq_high;
        logic [`LRM_DW-1:0]  rdata;
        logic                mode_change;
        logic                ext_wr;
        logic                ext_rd;
        logic [`LRM_AW-1:0]  ext_addr;
        logic [`LRM_DW-1:0]  ext_wdata;
        logic                ext_fsk_page;
        logic                ext_hf_bank;
    } lrm_state_t;

    // region of a register address
    function automatic lrm_region_t lrm_region_of(input logic [`LRM_AW-1:0] a);
        lrm_region_t r;
        r = lrm_rg_other;
        if (a == `LRM_ADDR_FIFO)
            r = lrm_rg_fifo;
        else if (a == `LRM_ADDR_OPMODE)
            r = lrm_rg_opmode;
        else if (a >= `LRM_ADDR_RSVD_LO && a <= `LRM_ADDR_RSVD_HI)
            r = lrm_rg_rsvd;
        else if (a == `LRM_ADDR_FRF_MSB)
            r = lrm_rg_frf;
        else if (a >= `LRM_ADDR_SHARED_LO && a <= `LRM_ADDR_SHARED_HI)
            r = lrm_rg_shared;
        return r;
    endfunction

endpackage

`default_nettype wire

// file: hw/lrm_page_dec.sv
`timescale 1ns/10ps
`default_nettype none

`include "lrm_params.svh"

module lrm_page_dec
(
    input  wire logic [`LRM_AW-1:0]  addr,
    input  wire logic                modem_select,
    input  wire logic                shared_page_access,
    output lrm_pkg::lrm_region_t     region,
    output logic                     fsk_page,
    output logic                     ext_hit
);
    import lrm_pkg::*;

    // ------------------------------------------------------------------
    // page decode
    // ------------------------------------------------------------------

    // fsk page in fsk mode, or in long-range mode through the overlay
    always_comb
    begin
        region   = lrm_region_of(addr);
        fsk_page = !modem_select ||
                   (shared_page_access && region == lrm_rg_shared);
        ext_hit  = (region == lrm_rg_shared) || (region == lrm_rg_other) ||
                   (region == lrm_rg_rsvd && !modem_select);
    end

endmodule

`default_nettype wire

// file: hw/lrm_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module lrm_fifo
#(
    parameter int W     = 8,
    parameter int DEPTH = 256
)
(
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire logic          flush,
    input  wire logic          push,
    input  wire logic [W-1:0]  push_data,
    input  wire logic          pop,
    output logic [W-1:0]       head,
    output logic               empty,
    output logic               full
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wptr;
        logic [AW:0] rptr;
    } lrm_fifo_state_t;

    lrm_fifo_state_t q;
    lrm_fifo_state_t d;
    logic [W-1:0]    mem [DEPTH];

    // ------------------------------------------------------------------
    // pointers
    // ------------------------------------------------------------------

    // flags from pointer comparison
    assign empty = (q.wptr == q.rptr);
    assign full  = (q.wptr[AW-1:0] == q.rptr[AW-1:0]) && (q.wptr[AW] != q.rptr[AW]);
    assign head  = mem[q.rptr[AW-1:0]];

    // flush outranks any access
    always_comb
    begin
        d = q;
        if (flush)
        begin
            d.rptr = q.wptr;
        end
        else
        begin
            if (push && !full)
                d.wptr = q.wptr + 1'b1;
            if (pop && !empty)
                d.rptr = q.rptr + 1'b1;
        end
    end

    // pointer registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    // storage, no reset needed
    always_ff @(posedge clk_sys)
    begin
        if (push && !full && !flush)
            mem[q.wptr[AW-1:0]] <= push_data;
    end

endmodule

`default_nettype wire

// file: hw/lrm_regs.sv
// Summary of operation
// - modem select bit 7 changes only in sleep; other writes ignored
// - in sleep the fifo is emptied and its data port inaccessible
// - long-range mode with shared bit set maps fsk page onto 0x0d-0x3f
// - shared bit 6 acts only in long-range mode; clear selects long-range page
// - long-range registers only in long-range mode, fsk registers in fsk mode or through the overlay
// - mode field codes eight modes, resets to standby, write triggers change
// - band bit 3: 0 high band bank, 1 low band bank, resets low band
// - register 0x06 holds carrier bits 23:16, resets to 0x6c
`timescale 1ns/10ps
`default_nettype none

`include "lrm_params.svh"

module lrm_regs
#(
    parameter int FIFO_DEPTH = `LRM_FIFO_DEPTH
)
(
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic [`LRM_AW-1:0]  reg_addr,
    input  wire logic [`LRM_DW-1:0]  reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [`LRM_DW-1:0]       reg_rdata,
    output logic                     modem_select,
    output logic                     shared_page_access,
    output logic                     band_bank_select,
    output lrm_pkg::lrm_mode_t       dev_mode,
    output logic                     mode_change,
    output logic [`LRM_DW-1:0]       carrier_freq_high,
    output logic                     ext_wr,
    output logic                     ext_rd,
    output logic [`LRM_AW-1:0]       ext_addr,
    output logic [`LRM_DW-1:0]       ext_wdata,
    output logic                     ext_fsk_page,
    output logic                     ext_hf_bank
);
    import lrm_pkg::*;

    // ------------------------------------------------------------------
    // state and helpers
    // ------------------------------------------------------------------

    lrm_state_t          q;
    lrm_state_t          d;
    lrm_region_t         region;
    logic                fsk_page;
    logic                ext_hit;
    logic                in_sleep;
    logic                fifo_ok;
    logic                fifo_push;
    logic                fifo_pop;
    logic [`LRM_DW-1:0]  fifo_head;
    logic                fifo_empty;
    logic                fifo_full;

    // read image of the operating-mode register
    function automatic logic [`LRM_DW-1:0] opmode_image(input lrm_state_t s);
        logic [`LRM_DW-1:0] v;
        v                                 = '0;
        v[`LRM_MODEM_BIT]                 = s.modem_select;
        v[`LRM_SHARED_BIT]                = s.shared_page_access;
        v[`LRM_RSVD_MSB:`LRM_RSVD_LSB]    = `LRM_RSVD_VALUE;
        v[`LRM_BAND_BIT]                  = s.band_bank_select;
        v[`LRM_MODE_MSB:`LRM_MODE_LSB]    = s.mode;
        return v;
    endfunction

    // ------------------------------------------------------------------
    // address decode and fifo
    // ------------------------------------------------------------------

    // page selection from the settings in force at this access
    lrm_page_dec u_dec
    (
        .addr               (reg_addr),
        .modem_select       (q.modem_select),
        .shared_page_access (q.shared_page_access),
        .region             (region),
        .fsk_page           (fsk_page),
        .ext_hit            (ext_hit)
    );

    // fifo port closed and fifo held empty while asleep
    assign in_sleep  = (q.mode == lrm_sleep);
    assign fifo_ok   = !in_sleep && (region == lrm_rg_fifo);
    assign fifo_push = reg_wr && fifo_ok;
    assign fifo_pop  = reg_rd && fifo_ok;

    lrm_fifo
    #(
        .W     (`LRM_DW),
        .DEPTH (FIFO_DEPTH)
    )
    u_fifo
    (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .flush     (in_sleep),
        .push      (fifo_push),
        .push_data (reg_wdata),
        .pop       (fifo_pop),
        .head      (fifo_head),
        .empty     (fifo_empty),
        .full      (fifo_full)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------

    // writes, read data and forwarding of accesses to the outer pages
    always_comb
    begin
        d             = q;
        d.mode_change = 1'b0;
        d.ext_wr      = 1'b0;
        d.ext_rd      = 1'b0;
        d.rdata       = `LRM_RDATA_IDLE;
        if (reg_wr)
        begin
            case (region)
                lrm_rg_opmode:
                begin
                    if (in_sleep)
                        d.modem_select = reg_wdata[`LRM_MODEM_BIT];
                    d.shared_page_access = reg_wdata[`LRM_SHARED_BIT];
                    d.band_bank_select   = reg_wdata[`LRM_BAND_BIT];
                    d.mode = lrm_mode_t'(reg_wdata[`LRM_MODE_MSB:`LRM_MODE_LSB]);
                    d.mode_change = 1'b1;
                end
                lrm_rg_frf:
                begin
                    d.carrier_freq_high = reg_wdata;
                end
                default:
                begin
                    d.mode_change = 1'b0;
                end
            endcase
        end
        if (reg_rd)
        begin
            case (region)
                lrm_rg_fifo:
                begin
                    if (fifo_ok && !fifo_empty)
                        d.rdata = fifo_head;
                end
                lrm_rg_opmode:
                begin
                    d.rdata = opmode_image(q);
                end
                lrm_rg_frf:
                begin
                    d.rdata = q.carrier_freq_high;
                end
                default:
                begin
                    d.rdata = `LRM_RDATA_IDLE;
                end
            endcase
        end
        if ((reg_wr || reg_rd) && ext_hit)
        begin
            d.ext_wr       = reg_wr;
            d.ext_rd       = reg_rd;
            d.ext_addr     = reg_addr;
            d.ext_wdata    = reg_wdata;
            d.ext_fsk_page = fsk_page;
            d.ext_hf_bank  = !q.band_bank_select;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------

    // reset gives fsk modem, standby, low band
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            q                    <= '0;
            q.modem_select       <= `LRM_MODEM_RST;
            q.shared_page_access <= `LRM_SHARED_RST;
            q.band_bank_select   <= `LRM_BAND_RST;
            q.mode               <= standby_state;
            q.carrier_freq_high  <= `LRM_FRF_MSB_RST;
            q.ext_fsk_page       <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign reg_rdata          = q.rdata;
    assign modem_select       = q.modem_select;
    assign shared_page_access = q.shared_page_access;
    assign band_bank_select   = q.band_bank_select;
    assign dev_mode           = q.mode;
    assign mode_change        = q.mode_change;
    assign carrier_freq_high  = q.carrier_freq_high;
    assign ext_wr             = q.ext_wr;
    assign ext_rd             = q.ext_rd;
    assign ext_addr           = q.ext_addr;
    assign ext_wdata          = q.ext_wdata;
    assign ext_fsk_page       = q.ext_fsk_page;
    assign ext_hf_bank        = q.ext_hf_bank;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------

    // access sequences
    sequence s_opmode_wr;
        reg_wr && reg_addr == `LRM_ADDR_OPMODE;
    endsequence

    sequence s_frf_wr;
        reg_wr && reg_addr == `LRM_ADDR_FRF_MSB;
    endsequence

    sequence s_frf_rd;
        reg_rd && reg_addr == `LRM_ADDR_FRF_MSB;
    endsequence

    sequence s_shared_acc;
        (reg_wr || reg_rd) && reg_addr >= `LRM_ADDR_SHARED_LO &&
            reg_addr <= `LRM_ADDR_SHARED_HI;
    endsequence

    a_modem_locked_awake: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_opmode_wr and (dev_mode != lrm_sleep) |=> $stable(modem_select))
        else $error("modem select changed outside sleep");

    a_modem_write_sleep: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_opmode_wr and (dev_mode == lrm_sleep) |=>
            modem_select == $past(reg_wdata[`LRM_MODEM_BIT]))
        else $error("modem select not taken in sleep");

    a_fifo_sleep_read: assert property (
        @(posedge clk_sys) disable iff (rst)
        reg_rd && reg_addr == `LRM_ADDR_FIFO && dev_mode == lrm_sleep |=>
            reg_rdata == `LRM_RDATA_IDLE)
        else $error("fifo readable in sleep");

    a_fifo_sleep_empty: assert property (
        @(posedge clk_sys) disable iff (rst)
        dev_mode == lrm_sleep |=> fifo_empty)
        else $error("fifo not emptied in sleep");

    a_shared_overlay_fsk: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_shared_acc and (modem_select && shared_page_access) |=>
            (ext_wr || ext_rd) && ext_fsk_page)
        else $error("overlay did not select fsk page");

    a_shared_clear_lr: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_shared_acc and (modem_select && !shared_page_access) |=>
            (ext_wr || ext_rd) && !ext_fsk_page)
        else $error("long-range page not selected");

    a_fsk_mode_page: assert property (
        @(posedge clk_sys) disable iff (rst)
        (reg_wr || reg_rd) && !modem_select && reg_addr >= `LRM_ADDR_SHARED_LO |=>
            (ext_wr || ext_rd) && ext_fsk_page)
        else $error("fsk mode reached long-range page");

    a_mode_trigger: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_opmode_wr |=> mode_change &&
            dev_mode == $past(reg_wdata[`LRM_MODE_MSB:`LRM_MODE_LSB]))
        else $error("mode write did not trigger");

    a_mode_pulse_only: assert property (
        @(posedge clk_sys) disable iff (rst)
        !(reg_wr && reg_addr == `LRM_ADDR_OPMODE) |=> !mode_change)
        else $error("mode change without write");

    a_band_follows: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_opmode_wr |=> band_bank_select == $past(reg_wdata[`LRM_BAND_BIT]))
        else $error("band select not written");

    a_frf_readback: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_frf_wr ##1 s_frf_rd |=> reg_rdata == $past(reg_wdata, 2))
        else $error("carrier high byte readback wrong");

    a_rsvd_read_zero: assert property (
        @(posedge clk_sys) disable iff (rst)
        reg_rd && modem_select && reg_addr >= `LRM_ADDR_RSVD_LO &&
            reg_addr <= `LRM_ADDR_RSVD_HI |=> reg_rdata == `LRM_RDATA_IDLE)
        else $error("reserved location read nonzero");

    a_opmode_current: assert property (
        @(posedge clk_sys) disable iff (rst)
        reg_rd && reg_addr == `LRM_ADDR_OPMODE |=>
            reg_rdata[`LRM_RSVD_MSB:`LRM_RSVD_LSB] == `LRM_RSVD_VALUE &&
            reg_rdata[`LRM_MODEM_BIT] == modem_select &&
            reg_rdata[`LRM_BAND_BIT] == band_bank_select &&
            reg_rdata[`LRM_MODE_MSB:`LRM_MODE_LSB] == dev_mode)
        else $error("operating mode readback wrong");

    a_bank_at_access: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_shared_acc |=> ext_hf_bank == !$past(band_bank_select))
        else $error("band bank not current at access");

    // write to one of the reserved locations
    sequence s_rsvd_wr;
        reg_wr && reg_addr >= `LRM_ADDR_RSVD_LO && reg_addr <= `LRM_ADDR_RSVD_HI;
    endsequence

    a_rsvd_not_forwarded: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_rsvd_wr and modem_select |=> !ext_wr)
        else $error("reserved write forwarded in long-range mode");

    a_shared_follows: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_opmode_wr |=> shared_page_access == $past(reg_wdata[`LRM_SHARED_BIT]))
        else $error("shared page bit not written");

    a_rdata_one_cycle: assert property (
        @(posedge clk_sys) disable iff (rst)
        !reg_rd |=> reg_rdata == `LRM_RDATA_IDLE)
        else $error("read data stood beyond its cycle");

    a_frf_held: assert property (
        @(posedge clk_sys) disable iff (rst)
        !(reg_wr && reg_addr == `LRM_ADDR_FRF_MSB) |=> $stable(carrier_freq_high))
        else $error("carrier high byte changed without a write");

endmodule

`default_nettype wire

// file: verification/lrm_host_model.sv
`timescale 1ns/10ps
`default_nettype none

`include "lrm_params.svh"

// host side of the register port: one-cycle strobes launched after a rising edge
module lrm_host_model
(
    input  wire logic                clk_sys,
    output logic [`LRM_AW-1:0]       reg_addr,
    output logic [`LRM_DW-1:0]       reg_wdata,
    output logic                     reg_wr,
    output logic                     reg_rd,
    input  wire logic [`LRM_DW-1:0]  reg_rdata
);
    // ----------------------------------------------------------------------
    // bus idle at time zero
    // ----------------------------------------------------------------------
    initial
    begin
        reg_addr  = '0;
        reg_wdata = '0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // write: returns just after the taking edge, once its updates have landed
    task automatic wr(input logic [`LRM_AW-1:0] a, input logic [`LRM_DW-1:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d; // released data shows no stale value
        #1;
    endtask

    // read: data stands only in the cycle after the taking edge
    task automatic rd(input logic [`LRM_AW-1:0] a, output logic [`LRM_DW-1:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // write then read with no gap between the two strobes
    task automatic wr_rd(input logic [`LRM_AW-1:0] a, input logic [`LRM_DW-1:0] d,
                         output logic [`LRM_DW-1:0] q);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        reg_wdata <= ~d;
        @(posedge clk_sys);
        reg_rd    <= 1'b0;
        #1;
        q = reg_rdata;
    endtask
endmodule

`default_nettype wire

// file: verification/lrm_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none

`include "lrm_params.svh"

module lrm_regs_tb;
    import lrm_pkg::*;
    localparam int DEPTH = 4;

    logic                clk_sys = 1'b0;
    logic                rst = 1'b1;
    logic [`LRM_AW-1:0]  reg_addr;
    logic [`LRM_DW-1:0]  reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [`LRM_DW-1:0]  reg_rdata;
    logic                modem_select;
    logic                shared_page_access;
    logic                band_bank_select;
    lrm_mode_t           dev_mode;
    logic                mode_change;
    logic [`LRM_DW-1:0]  carrier_freq_high;
    logic                ext_wr;
    logic                ext_rd;
    logic [`LRM_AW-1:0]  ext_addr;
    logic [`LRM_DW-1:0]  ext_wdata;
    logic                ext_fsk_page;
    logic                ext_hf_bank;
    logic [`LRM_DW-1:0]  rv;
    int                  mismatches = 0;
    int                  n_compared = 0;
    int                  cycles = 0;

    // ----------------------------------------------------------------------
    // clock, host and device
    // ----------------------------------------------------------------------
    always #2 clk_sys = ~clk_sys;

    lrm_host_model i_host
    (
        .clk_sys   (clk_sys),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata)
    );

    lrm_regs #(.FIFO_DEPTH(DEPTH)) i_dut
    (
        .clk_sys            (clk_sys),
        .rst                (rst),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_rdata          (reg_rdata),
        .modem_select       (modem_select),
        .shared_page_access (shared_page_access),
        .band_bank_select   (band_bank_select),
        .dev_mode           (dev_mode),
        .mode_change        (mode_change),
        .carrier_freq_high  (carrier_freq_high),
        .ext_wr             (ext_wr),
        .ext_rd             (ext_rd),
        .ext_addr           (ext_addr),
        .ext_wdata          (ext_wdata),
        .ext_fsk_page       (ext_fsk_page),
        .ext_hf_bank        (ext_hf_bank)
    );

    // ----------------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    // write to an outer page and judge the forwarded access
    task automatic fwd(input logic [6:0] a, input logic fsk, input logic hf);
        i_host.wr(a, 8'hc3);
        chk("ext_wr", ext_wr, 8'h01);
        chk("ext_addr", ext_addr, a);
        chk("ext_wdata", ext_wdata, 8'hc3);
        chk("ext_fsk_page", ext_fsk_page, fsk);
        chk("ext_hf_bank", ext_hf_bank, hf);
    endtask

    // ----------------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------------
    task automatic t_reset();
        chk("band", band_bank_select, 8'h01);
        chk("mode", dev_mode, standby_state);
        i_host.rd(7'h01, rv);
        chk("opmode", rv, 8'h09);
        i_host.rd(7'h06, rv);
        chk("carrier", rv, 8'h6c);
        @(posedge clk_sys);
        #1;
        chk("rdata idle", reg_rdata, 8'h00);
        for (int a = 2; a <= 5; a++)
        begin
            i_host.rd(7'(a), rv);
            chk("reserved", rv, 8'h00);
        end
    endtask

    task automatic t_modes();
        i_host.wr(7'h01, 8'h89);
        chk("mode_change", mode_change, 8'h01);
        chk("modem locked", modem_select, 8'h00);
        for (int m = 0; m < 8; m++)
        begin
            i_host.wr(7'h01, 8'h08 | 8'(m));
            chk("mode", dev_mode, 8'(m));
        end
        i_host.wr(7'h01, 8'h88);
        chk("modem from cad", modem_select, 8'h00);
        i_host.wr(7'h01, 8'h89);
        chk("modem in sleep", modem_select, 8'h01);
        i_host.wr(7'h01, 8'h39);
        i_host.rd(7'h01, rv);
        chk("opmode", rv, 8'h89);
    endtask

    task automatic t_fifo();
        for (int i = 1; i <= 5; i++)
            i_host.wr(7'h00, 8'(i * 17));
        for (int i = 1; i <= 5; i++)
        begin
            i_host.rd(7'h00, rv);
            chk("fifo", rv, (i <= DEPTH) ? 8'(i * 17) : 8'h00);
        end
        i_host.wr(7'h00, 8'h5a);
        i_host.wr(7'h01, 8'h88);
        i_host.wr(7'h00, 8'h77);
        i_host.rd(7'h00, rv);
        chk("fifo sleep", rv, 8'h00);
        i_host.wr(7'h01, 8'h89);
        i_host.rd(7'h00, rv);
        chk("fifo emptied", rv, 8'h00);
    endtask

    task automatic t_pages();
        fwd(7'h20, '0, '0);
        i_host.wr(7'h01, 8'hc9);
        chk("shared set", shared_page_access, 8'h01);
        fwd(7'h0d, '1, '0);
        fwd(7'h3f, '1, '0);
        fwd(7'h40, '0, '0);
        fwd(7'h0c, '0, '0);
        i_host.wr(7'h01, 8'h81);
        chk("shared clear", shared_page_access, 8'h00);
        fwd(7'h0d, '0, '1);
        i_host.wr(7'h04, 8'hff);
        chk("rsvd not forwarded", ext_wr, 8'h00);
        i_host.rd(7'h04, rv);
        chk("rsvd", rv, 8'h00);
        i_host.wr(7'h01, 8'h80);
        i_host.wr(7'h01, 8'h01);
        fwd(7'h20, '1, '1);
        fwd(7'h02, '1, '1);
        i_host.rd(7'h30, rv);
        chk("ext_rd", ext_rd, 8'h01);
        chk("outer read", rv, 8'h00);
    endtask

    task automatic t_carrier();
        i_host.wr(7'h06, 8'ha5);
        chk("carrier port", carrier_freq_high, 8'ha5);
        i_host.rd(7'h06, rv);
        chk("carrier", rv, 8'ha5);
        i_host.wr_rd(7'h06, 8'h3c, rv);
        chk("carrier back", rv, 8'h3c);
    endtask

    // ----------------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_modes();
        t_fifo();
        t_pages();
        t_carrier();
        end_of_test();
    end
endmodule

`default_nettype wire
